// *** pkg/mcs_pkg.sv ***
// ****************************************************************
// mission control and status shared definitions
// ****************************************************************
package mcs_pkg;

    // ****************************************************************
    // register byte addresses
    // ****************************************************************
    localparam logic [15:0] MCS_ADDR_RTC_CTRL = 16'h0212; // clock_oscillator_control
    localparam logic [15:0] MCS_ADDR_SETUP = 16'h0213; // mission_setup
    localparam logic [15:0] MCS_ADDR_ALARM = 16'h0214; // alarm_flags
    localparam logic [15:0] MCS_ADDR_STATE = 16'h0215; // mission_state_flags
    localparam logic [15:0] MCS_ADDR_DELAY0 = 16'h0216; // start_delay_minutes low byte
    localparam logic [15:0] MCS_ADDR_DELAY1 = 16'h0217; // start_delay_minutes centre byte
    localparam logic [15:0] MCS_ADDR_DELAY2 = 16'h0218; // start_delay_minutes high byte
    localparam logic [15:0] MCS_ADDR_TS0 = 16'h0219; // first_sample_time, six bytes up to 021Eh
    localparam logic [15:0] MCS_ADDR_TS5 = 16'h021E;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int MCS_RTC_OSC_RUN = 0; // osc_run
    localparam int MCS_RTC_SEC_SEL = 1; // seconds_tick_select
    localparam int MCS_SU_LOG_EN = 0; // logging_enable
    localparam int MCS_SU_FIXED0 = 1; // host keeps this at 0
    localparam int MCS_SU_WIDE = 2; // log_format_wide
    localparam int MCS_SU_DONTCARE = 3; // no function while bit 1 is 0
    localparam int MCS_SU_ROLL = 4; // rollover_enable
    localparam int MCS_SU_SOA = 5; // start_on_alarm
    localparam int MCS_AL_LOW = 0; // low_temp_flag
    localparam int MCS_AL_HIGH = 1; // high_temp_flag
    localparam int MCS_AL_BOR = 7; // battery_reset_flag
    localparam int MCS_GS_ACTIVE = 1; // mission_active
    localparam int MCS_GS_CLEARED = 3; // log_cleared
    localparam int MCS_GS_AWAIT = 4; // awaiting_alarm

    // ****************************************************************
    // fixed read patterns and reset values
    // ****************************************************************
    localparam logic [7:0] MCS_SETUP_ONES = 8'hC0; // bits 7 and 6 always read 1
    localparam logic [7:0] MCS_ALARM_ONES = 8'h70; // bits 6 to 4 read 1
    localparam logic [7:0] MCS_STATE_ONES = 8'hC0; // bits 7 and 6 read 1
    localparam logic [5:0] MCS_SETUP_RESET = 6'h00;
    localparam logic [23:0] MCS_DELAY_RESET = 24'h000000;
    localparam logic [47:0] MCS_TS_RESET = 48'h000000000000;
    localparam logic MCS_BOR_RESET = 1'b1; // every power-on reset leaves the flag up
    localparam logic [15:0] MCS_LOG_BASE = 16'h1000; // first data-log byte

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam logic [5:0] MCS_SECONDS_PER_MINUTE = 6'h3C;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic wr; // one-cycle write strobe
        logic rd; // one-cycle read strobe
        logic [15:0] addr; // byte address
        logic [7:0] wdata; // write byte
    } mcs_reg_req_t;

    typedef struct packed {
        logic force_conv; // forced conversion command
        logic start; // start mission command
        logic stop; // stop mission command
        logic clear; // clear memory command
    } mcs_cmd_t;

    typedef struct packed {
        logic high_en; // high alarm enable
        logic low_en; // low alarm enable
        logic [7:0] thr_high; // high threshold code
        logic [7:0] thr_low; // low threshold code
    } mcs_alarm_cfg_t;

    typedef struct packed {
        logic done; // one-cycle result strobe
        logic [7:0] msb; // result high byte
        logic [7:0] lsb; // result low byte
    } mcs_conv_t;

    typedef struct packed {
        logic wr; // one-cycle byte write
        logic [15:0] addr; // data-log byte address
        logic [7:0] data; // byte
    } mcs_log_t;

    typedef enum logic [2:0] {MS_IDLE, MS_DELAY, MS_WAIT, MS_LOG, MS_FULL} mcs_mode_t;
    typedef enum logic [1:0] {CK_NONE, CK_FORCED, CK_TEST, CK_LOG} mcs_conv_kind_t;

endpackage : mcs_pkg

// *** verilog/mcs_interval.sv ***
`timescale 1ns/1ps
`default_nettype none
// reloading down-counter: one expire pulse every period ticks
module mcs_interval
    import mcs_pkg::*;
#(
    parameter int W = 24
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic restart, // reload without expiring
    input wire logic tick, // one count per pulse
    input wire logic [W-1:0] period, // zero behaves as one
    output logic expire // one-cycle pulse
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [W-1:0] count; // ticks left
        logic expire; // pulse
    } mcs_iv_state_t;

    mcs_iv_state_t s; // registered state
    mcs_iv_state_t next_s; // next state
    logic [W-1:0] load; // effective period

    // next state: a zero period is bent to one, so it expires on every tick
    always_comb begin
        load = (period == '0) ? W'(1) : period;
        next_s = s;
        next_s.expire = 1'b0;
        if (restart) begin
            next_s.count = load;
        end else if (tick) begin
            if (s.count <= W'(1)) begin
                next_s.expire = 1'b1;
                next_s.count = load;
            end else begin
                next_s.count = s.count - W'(1);
            end
        end
    end

    // registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign expire = s.expire;

endmodule : mcs_interval
`default_nettype wire

// *** verilog/mcs_alarm_cmp.sv ***
`timescale 1ns/1ps
`default_nettype none
// threshold comparison on the result high byte only
module mcs_alarm_cmp
    import mcs_pkg::*;
(
    input wire mcs_alarm_cfg_t cfg,
    input wire logic [7:0] msb,
    output logic hi, // at or above high threshold, enabled
    output logic lo // at or below low threshold, enabled
);

    // compare: both limits inclusive
    always_comb begin
        hi = cfg.high_en && (msb >= cfg.thr_high); // RULE14
        lo = cfg.low_en && (msb <= cfg.thr_low); // RULE15
    end

endmodule : mcs_alarm_cmp
`default_nettype wire

// *** verilog/mcs_top.sv ***
//
// Contract
// RULE1: select bit one: minutes at 0, seconds at 1
// RULE2: oscillator run bit starts or stops the clock
// RULE3: forced conversion or start sets oscillator run
// RULE4: setup read-only in mission; bits 7,6 read 1
// RULE5: host writes setup bit 1 as zero
// RULE6: start-on-alarm waits for alarm, logs alarming sample
// RULE7: alarm-test conversions leave sample counter alone
// RULE8: rollover wraps log to its start
// RULE9: no rollover: stop logging, mission stays active
// RULE10: wide format, high byte at lower address
// RULE11: logging enable needed; log starts at 1000h
// RULE12: alarm flags read-only, fixed bits, cleared together
// RULE13: battery reset flag set after power-on reset
// RULE14: high flag at or above high threshold
// RULE15: low flag at or below low threshold
// RULE16: awaiting flag set by alarm-mode start, cleared by alarm
// RULE17: host clears stale awaiting flag via forced conversion
// RULE18: log-cleared set by clear, dropped by start
// RULE19: start only succeeds while log-cleared is set
// RULE20: mission-active shows a mission in progress
// RULE21: state flags read-only with fixed filler bits
// RULE22: start delay counts minutes before first sample
// RULE23: alarm tests wait for the start delay
// RULE24: timestamp captures time of first sample
// RULE25: stopped oscillator freezes sample and delay counting
//
`timescale 1ns/1ps
`default_nettype none
module mcs_top
    import mcs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire mcs_reg_req_t reg_req, // byte register access
    output logic [7:0] reg_rdata, // read byte, one cycle after rd
    output logic reg_rvalid, // read data strobe
    input wire mcs_cmd_t cmd, // mission commands, one-cycle pulses
    input wire logic sec_tick, // one pulse per RTC second
    input wire logic [47:0] rtc_time, // current RTC date and time
    input wire logic [13:0] sample_rate, // sample interval in units
    input wire mcs_alarm_cfg_t alarm_cfg, // thresholds and enables
    input wire mcs_conv_t conv, // conversion result
    input wire logic log_full, // current log address is the last one
    output logic conv_req, // start a conversion, pulse
    output logic conv_narrow, // requested conversion is 8-bit
    output mcs_log_t log_out, // data-log byte writes
    output logic sample_inc, // advance mission sample counter, pulse
    output logic sample_clr, // zero mission sample counter, pulse
    output logic osc_running // oscillator run bit
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        mcs_mode_t st; // mission mode
        logic osc_run; // oscillator running
        logic sec_sel; // seconds_tick_select
        logic [5:0] setup; // mission_setup bits 5..0
        logic [23:0] delay; // start_delay_minutes
        logic [47:0] ts; // first_sample_time
        logic ts_taken; // first sample already stamped
        logic bor; // battery_reset_flag
        logic high_temp_flag; // high_temp_flag
        logic low_temp_flag; // low_temp_flag
        logic await; // awaiting_alarm
        logic cleared; // log_cleared
        mcs_conv_kind_t kind; // outstanding conversion
        logic conv_req; // request pulse
        logic conv_narrow; // request width
        mcs_log_t log; // byte write
        logic [15:0] log_addr; // next data-log address
        logic lsb_pend; // low byte still to write
        logic [7:0] lsb_byte; // held low byte
        logic [7:0] rdata; // read data
        logic rvalid; // read strobe
        logic sample_inc; // pulse
        logic sample_clr; // pulse
    } mcs_state_t;

    mcs_state_t s; // registered state
    mcs_state_t next_s; // next state
    logic active; // a mission is running
    logic osc_tick; // seconds that pass while the oscillator runs
    logic minute_tick; // minute pulse
    logic unit_tick; // sample rate unit pulse
    logic sample_due; // sample interval elapsed
    logic delay_done; // start delay elapsed
    logic restart_iv; // realign sample interval counter
    logic hi; // high alarm on current result
    logic lo; // low alarm on current result
    logic start_ok; // start command accepted
    logic [7:0] rd_mux; // read multiplexer
    logic log_sample; // result is to be logged
    logic [7:0] log_lsb; // low byte to log

    // ****************************************************************
    // time base
    // ****************************************************************
    // counters see no ticks while stopped
    always_comb begin
        active = (s.st != MS_IDLE);
        osc_tick = sec_tick && s.osc_run; // RULE25
        unit_tick = s.sec_sel ? osc_tick : minute_tick; // RULE1
        start_ok = cmd.start && !active && s.cleared && s.setup[MCS_SU_LOG_EN]; // RULE19 RULE11
        restart_iv = start_ok || (s.st == MS_DELAY && delay_done);
    end

    mcs_interval #(.W(6)) u_minute (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .restart(start_ok),
        .tick(osc_tick),
        .period(MCS_SECONDS_PER_MINUTE),
        .expire(minute_tick)
    );

    mcs_interval #(.W(14)) u_sample (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .restart(restart_iv),
        .tick(unit_tick),
        .period(sample_rate),
        .expire(sample_due)
    );

    mcs_interval #(.W(24)) u_delay (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .restart(start_ok),
        .tick(minute_tick), // RULE22
        .period(s.delay),
        .expire(delay_done)
    );

    mcs_alarm_cmp u_cmp (
        .cfg(alarm_cfg),
        .msb(conv.msb),
        .hi(hi),
        .lo(lo)
    );

    // ****************************************************************
    // read multiplexer
    // ****************************************************************
    // unmapped addresses read as zero
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_req.addr)
            MCS_ADDR_RTC_CTRL: rd_mux = {6'h00, s.sec_sel, s.osc_run};
            MCS_ADDR_SETUP: rd_mux = MCS_SETUP_ONES | {2'h0, s.setup}; // RULE4
            MCS_ADDR_ALARM: rd_mux = MCS_ALARM_ONES | {s.bor, 5'h00, s.high_temp_flag, s.low_temp_flag}; // RULE12 RULE13
            MCS_ADDR_STATE: rd_mux = MCS_STATE_ONES | {3'h0, s.await, s.cleared, 1'b0, active, 1'b0}; // RULE21 RULE20
            MCS_ADDR_DELAY0: rd_mux = s.delay[7:0];
            MCS_ADDR_DELAY1: rd_mux = s.delay[15:8];
            MCS_ADDR_DELAY2: rd_mux = s.delay[23:16];
            default: begin
                if (reg_req.addr >= MCS_ADDR_TS0 && reg_req.addr <= MCS_ADDR_TS5) begin
                    rd_mux = s.ts[8 * 3'(reg_req.addr - MCS_ADDR_TS0) +: 8];
                end
            end
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    // the later effect wins for every flag: command effects come first, results after
    always_comb begin
        next_s = s;
        next_s.conv_req = 1'b0;
        next_s.log.wr = 1'b0;
        next_s.rvalid = reg_req.rd;
        next_s.sample_inc = 1'b0;
        next_s.sample_clr = 1'b0;
        log_sample = 1'b0;
        log_lsb = s.setup[MCS_SU_WIDE] ? conv.lsb : 8'h00;
        if (reg_req.rd) begin
            next_s.rdata = rd_mux;
        end
        // register writes: configuration is frozen during a mission
        if (reg_req.wr && !active) begin
            unique case (reg_req.addr)
                MCS_ADDR_RTC_CTRL: begin
                    next_s.osc_run = reg_req.wdata[MCS_RTC_OSC_RUN]; // RULE2
                    next_s.sec_sel = reg_req.wdata[MCS_RTC_SEC_SEL]; // RULE1
                end
                MCS_ADDR_SETUP: next_s.setup = reg_req.wdata[5:0]; // RULE4 RULE5
                MCS_ADDR_DELAY0: next_s.delay[7:0] = reg_req.wdata;
                MCS_ADDR_DELAY1: next_s.delay[15:8] = reg_req.wdata;
                MCS_ADDR_DELAY2: next_s.delay[23:16] = reg_req.wdata;
                default: begin
                    next_s.delay = next_s.delay; // read-only or foreign address
                end
            endcase
        end
        // commands
        if (cmd.force_conv || cmd.start) begin
            next_s.osc_run = 1'b1; // RULE3
        end
        if (cmd.force_conv && s.kind == CK_NONE) begin
            next_s.kind = CK_FORCED;
            next_s.conv_req = 1'b1;
            next_s.conv_narrow = !s.setup[MCS_SU_WIDE];
        end
        if (cmd.clear && !active) begin
            next_s.ts = MCS_TS_RESET; // RULE18
            next_s.ts_taken = 1'b0;
            next_s.high_temp_flag = 1'b0; // RULE12
            next_s.low_temp_flag = 1'b0;
            next_s.bor = 1'b0;
            next_s.cleared = 1'b1; // RULE18
            next_s.sample_clr = 1'b1;
        end
        if (start_ok) begin
            next_s.cleared = 1'b0; // RULE18
            next_s.await = s.setup[MCS_SU_SOA]; // RULE16
            next_s.log_addr = MCS_LOG_BASE; // RULE11
            next_s.lsb_pend = 1'b0;
            next_s.st = (s.delay != '0) ? MS_DELAY : (s.setup[MCS_SU_SOA] ? MS_WAIT : MS_LOG); // RULE22 RULE23
            if (s.delay == '0) begin
                next_s.kind = s.setup[MCS_SU_SOA] ? CK_TEST : CK_LOG;
                next_s.conv_req = 1'b1;
                next_s.conv_narrow = s.setup[MCS_SU_SOA] || !s.setup[MCS_SU_WIDE]; // RULE6
            end
        end
        if (cmd.stop && active) begin
            next_s.st = MS_IDLE; // RULE20
        end
        // sampling: the delay end takes the first sample at once
        if (((s.st == MS_DELAY && delay_done) || ((s.st == MS_WAIT || s.st == MS_LOG) && sample_due))
            && !cmd.stop && s.kind == CK_NONE) begin
            next_s.kind = (s.st == MS_LOG) ? CK_LOG : (s.setup[MCS_SU_SOA] ? CK_TEST : CK_LOG); // RULE23
            next_s.conv_req = 1'b1;
            next_s.conv_narrow = (next_s.kind == CK_TEST) || !s.setup[MCS_SU_WIDE]; // RULE6 RULE10
            if (s.st == MS_DELAY) begin
                next_s.st = s.setup[MCS_SU_SOA] ? MS_WAIT : MS_LOG;
            end
        end
        // results
        if (conv.done && s.kind != CK_NONE) begin
            next_s.kind = CK_NONE;
            if (hi || lo) begin
                next_s.await = 1'b0; // RULE16 RULE17
            end
            if (s.kind == CK_FORCED || active) begin
                next_s.high_temp_flag |= hi; // RULE14
                next_s.low_temp_flag |= lo; // RULE15
            end
            if (s.kind == CK_TEST && s.st == MS_WAIT && (hi || lo)) begin
                log_sample = 1'b1; // RULE6
                log_lsb = 8'h00;
                next_s.st = MS_LOG;
            end else if (s.kind == CK_LOG && s.st == MS_LOG) begin
                log_sample = 1'b1;
                next_s.sample_inc = 1'b1; // RULE7
            end
        end
        // data-log byte writes
        if (log_sample) begin
            if (!s.ts_taken) begin
                next_s.ts = rtc_time; // RULE24
                next_s.ts_taken = 1'b1;
            end
            next_s.log.wr = 1'b1;
            next_s.log.addr = s.log_addr;
            next_s.log.data = conv.msb; // RULE10
            next_s.lsb_pend = s.setup[MCS_SU_WIDE];
            next_s.lsb_byte = log_lsb;
        end else if (s.lsb_pend && !s.log.wr && s.st == MS_LOG) begin
            next_s.log.wr = 1'b1;
            next_s.log.addr = s.log_addr;
            next_s.log.data = s.lsb_byte; // RULE10
            next_s.lsb_pend = 1'b0;
        end
        // address advance after each byte the log takes
        if (s.log.wr) begin
            if (log_full) begin
                if (s.setup[MCS_SU_ROLL]) begin
                    next_s.log_addr = MCS_LOG_BASE; // RULE8
                end else begin
                    next_s.lsb_pend = 1'b0;
                    if (next_s.st == MS_LOG) begin
                        next_s.st = MS_FULL; // RULE9
                    end
                end
            end else begin
                next_s.log_addr = s.log_addr + 16'h0001;
            end
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // reset takes constants only; the battery flag rises with every reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.st <= MS_IDLE;
            s.kind <= CK_NONE;
            s.setup <= MCS_SETUP_RESET;
            s.delay <= MCS_DELAY_RESET;
            s.ts <= MCS_TS_RESET;
            s.bor <= MCS_BOR_RESET; // RULE13
            s.log_addr <= MCS_LOG_BASE;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // outputs, all from flip-flops
    // ****************************************************************
    assign reg_rdata = s.rdata;
    assign reg_rvalid = s.rvalid;
    assign conv_req = s.conv_req;
    assign conv_narrow = s.conv_narrow;
    assign log_out = s.log;
    assign sample_inc = s.sample_inc;
    assign sample_clr = s.sample_clr;
    assign osc_running = s.osc_run;

endmodule : mcs_top
`default_nettype wire

// *** dv/mcs_conv_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// conversion engine stand-in: answers each request after LAT cycles
// ****************************************************************
module mcs_conv_model
    import mcs_pkg::*;
#(
    parameter int LAT = 3
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic conv_req,
    input wire logic [15:0] temp, // result to hand back
    output mcs_conv_t conv
);
    int cnt; // cycles left, 0 when idle
    // result bytes are only meaningful with done; elsewhere they toggle so a late sample is caught
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            conv <= '0;
        end else begin
            conv.done <= (cnt == 1);
            {conv.msb, conv.lsb} <= (cnt == 1) ? temp : ~{conv.msb, conv.lsb};
            cnt <= conv_req ? LAT : (cnt > 0 ? cnt - 1 : 0);
        end
    end
endmodule : mcs_conv_model
`default_nettype wire

// *** dv/mcs_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// port-level checks on the mission control block
// ****************************************************************
module mcs_assertions
    import mcs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire mcs_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire mcs_cmd_t cmd,
    input wire logic conv_req,
    input wire mcs_log_t log_out,
    input wire logic sample_inc,
    input wire logic osc_running
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_read_answer: assert property (reg_req.rd |=> reg_rvalid) else $error("read not answered");
    a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_req.rd)) else $error("stray read strobe");
    a_setup_ones: assert property (reg_req.rd && reg_req.addr == MCS_ADDR_SETUP |=> reg_rdata[7:6] == 2'h3)
        else $error("setup filler bits wrong");
    a_alarm_fixed: assert property (reg_req.rd && reg_req.addr == MCS_ADDR_ALARM |=> reg_rdata[6:2] == 5'h1C)
        else $error("alarm filler bits wrong");
    a_state_fixed: assert property (reg_req.rd && reg_req.addr == MCS_ADDR_STATE
        |=> {reg_rdata[7:5], reg_rdata[2], reg_rdata[0]} == 5'h18) else $error("state filler bits wrong");
    a_cmd_starts_osc: assert property (cmd.force_conv || cmd.start |=> osc_running) else $error("osc not started");
    a_conv_needs_osc: assert property (conv_req |-> osc_running) else $error("conversion with osc off");
    a_log_floor: assert property (log_out.wr |-> log_out.addr >= MCS_LOG_BASE) else $error("log below base");
    a_wide_pair: assert property (log_out.wr ##2 log_out.wr |->
        log_out.addr == $past(log_out.addr) + 16'h0001 || log_out.addr == MCS_LOG_BASE) else $error("byte order");
    a_inc_with_log: assert property (sample_inc |-> log_out.wr) else $error("count without log");
    c_pair: cover property (log_out.wr ##2 log_out.wr);
    c_forced: cover property (cmd.force_conv ##1 conv_req);
    c_sample: cover property (sample_inc);
endmodule : mcs_assertions
bind mcs_top mcs_assertions u_mcs_chk (.ref_clk, .rst_n, .reg_req, .reg_rdata, .reg_rvalid, .cmd, .conv_req,
    .log_out, .sample_inc, .osc_running);
`default_nettype wire

// *** dv/mission_control_status_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module mission_control_status_tb
    import mcs_pkg::*;
;
    // ****************************************************************
    // stimulus and design
    // ****************************************************************
    logic ref_clk = 0, rst_n = 0, sec_tick = 0, log_full = 0;
    mcs_reg_req_t req = '0;
    mcs_cmd_t cmd = '0;
    mcs_alarm_cfg_t acfg = '{1'b1, 1'b1, 8'h02, 8'h05}; // high level is the +15 C code
    logic [15:0] temp = 16'hFF00;
    logic [47:0] rtc = 48'h211215093045; // byte 0 holds seconds
    logic [7:0] rdata;
    logic rvalid, conv_req, narrow, inc, clr, osc;
    mcs_conv_t conv;
    mcs_log_t lo;
    int miscompares = 0, comparisons = 0, incs = 0;
    logic [23:0] log_q[$]; // address and byte of each log write
    always #10 ref_clk = ~ref_clk;
    mcs_top dut (.ref_clk, .rst_n, .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid), .cmd, .sec_tick,
        .rtc_time(rtc), .sample_rate(14'h0001), .alarm_cfg(acfg), .conv, .log_full, .conv_req,
        .conv_narrow(narrow), .log_out(lo), .sample_inc(inc), .sample_clr(clr), .osc_running(osc));
    mcs_conv_model u_conv (.ref_clk, .rst_n, .conv_req, .temp, .conv);
    // record log traffic so order and contents can be checked afterwards
    always @(posedge ref_clk) begin
        if (lo.wr === 1'b1) log_q.push_back({lo.addr, lo.data});
        if (inc === 1'b1) incs++;
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk) req <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk) req <= '0;
    endtask : wr
    // read answer stands just after the edge that takes the read
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge ref_clk) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk) req <= '0;
        #1 chk({rvalid, rdata}, {1'b1, e});
    endtask : rd
    // command pulse; returns just after the edge that takes it
    task automatic pulse(input mcs_cmd_t c);
        @(posedge ref_clk) cmd <= c;
        @(posedge ref_clk) cmd <= '0;
        #1;
    endtask : pulse
    task automatic final_report;
        if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    // ****************************************************************
    // table: optional write, then read back
    // ****************************************************************
    typedef struct packed { logic w; logic [15:0] a; logic [7:0] d; logic [7:0] e; } mcs_row_t;
    mcs_row_t rows[12] = '{
        '{1'b0, 16'h0214, 8'h00, 8'hF0},
        '{1'b0, 16'h0215, 8'h00, 8'hC0},
        '{1'b0, 16'h0213, 8'h00, 8'hC0},
        '{1'b0, 16'h0212, 8'h00, 8'h00},
        '{1'b0, 16'h0300, 8'h00, 8'h00},
        '{1'b1, 16'h0213, 8'h00, 8'hC0},
        '{1'b1, 16'h0213, 8'h15, 8'hD5},
        '{1'b1, 16'h0212, 8'h02, 8'h02},
        '{1'b1, 16'h0214, 8'hFF, 8'hF0},
        '{1'b1, 16'h0215, 8'hFF, 8'hC0},
        '{1'b1, 16'h0217, 8'h5A, 8'h5A},
        '{1'b1, 16'h0217, 8'h00, 8'h00}};
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1;
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        // forced conversions, the first with the oscillator stopped, hot then cold
        pulse('{1'b1, 1'b0, 1'b0, 1'b0});
        chk({osc, conv_req}, 2'b11);
        repeat (8) @(posedge ref_clk);
        rd(16'h0214, 8'hF2);
        temp <= 16'h0000;
        pulse('{1'b1, 1'b0, 1'b0, 1'b0});
        repeat (8) @(posedge ref_clk);
        rd(16'h0214, 8'hF3);
        rd(16'h0212, 8'h03);
        // clear memory, then a wide mission with no delay
        pulse('{1'b0, 1'b0, 1'b0, 1'b1});
        chk(clr, 1'b1);
        rd(16'h0214, 8'h70);
        rd(16'h0215, 8'hC8);
        temp <= 16'h5460;
        pulse('{1'b0, 1'b1, 1'b0, 1'b0});
        chk({conv_req, narrow}, 2'b10);
        for (int k = 0; k < 50 && log_q.size() < 2; k++) @(posedge ref_clk);
        if (log_q.size() < 2) begin
            miscompares++;
            final_report();
        end
        chk(log_q[0], 24'h100054);
        chk(log_q[1], 24'h100160);
        chk(incs, 1);
        rd(16'h0215, 8'hC2);
        rd(16'h0219, 8'h45);
        wr(16'h0213, 8'h00);
        rd(16'h0213, 8'hD5);
        pulse('{1'b0, 1'b0, 1'b1, 1'b0});
        rd(16'h0215, 8'hC0);
        final_report();
    end
    // hang guard
    initial begin
        #2000000;
        miscompares++;
        final_report();
    end
endmodule : mission_control_status_tb
`default_nettype wire
